//--- host_sink.sv
// Host processor model on the tail-tagged port: takes gate verdicts.
// Assumes the gate's clock and a stall line driven by the bench.
`timescale 1ns/1ps
module host_sink (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Bench control
    input  wire logic                       stall,
    // Verdict stream
    input  wire logic                       verdict_valid,
    input  wire stp_gate_pkg::pkt_verdict_s verdict,
    output logic                            verdict_ready,
    // Frames accepted for delivery, for the bench
    output logic [7:0]                      taken
);
    import stp_gate_pkg::*;
    assign verdict_ready = !stall;
    // Count only verdicts that leave somewhere
    always_ff @(posedge clk) begin
        if (reset) begin
            taken <= 8'h00;
        end else if (verdict_valid && verdict_ready && !verdict.drop) begin
            taken <= taken + 8'h01;
        end
    end
endmodule : host_sink

//--- stp_gate.sv
// Spanning tree port gate: descriptor FIFO and per-port state gating.
// Assumes lookup logic feeds descriptors and drains verdicts on clk.
`timescale 1ns/1ps

// Small FIFO of flip-flops between lookup and gate
module stp_desc_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW-1:0]    wr_ptr;       // Write index
    logic [AW-1:0]    rd_ptr;       // Read index
    logic [CW-1:0]    count;        // Words held
    wire              push;
    wire              pop;
    wire  [CW-1:0]    next_count;

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign out_valid  = (count != '0);
    assign out_data   = mem[rd_ptr];
    assign next_count = count + CW'(push) - CW'(pop);

    // Pointers and count; ready is a flop so back-pressure is clean
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count    <= next_count;
            in_ready <= (next_count != FULL);
        end
    end

    // Data store, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    a_fifo_full_stall:
    assert property (@(posedge clk) disable iff (reset)
        (count == FULL) |-> !in_ready)
        else $error("fifo ready while full");

    c_fifo_full:
    cover property (@(posedge clk) disable iff (reset) count == FULL);
endmodule : stp_desc_fifo

module stp_gate (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [7:0]                addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic [31:0]                    rdata,
    // Descriptors from lookup
    input  wire logic                      desc_valid,
    input  wire stp_gate_pkg::pkt_desc_s   desc,
    output logic                           desc_ready,
    // Verdicts to queue manager
    output logic                           verdict_valid,
    output stp_gate_pkg::pkt_verdict_s     verdict,
    input  wire logic                      verdict_ready,
    // Table flush requests, one per port
    output logic [2:0]                     flush
);
    import stp_gate_pkg::*;

    logic [3:0] ctrl [NPORT];  // Per-port control bits
    logic [7:0] drop_cnt;      // Dropped packet count
    logic       f_valid;       // FIFO head valid
    pkt_desc_s  head;          // FIFO head

    // Bit vectors gathered from control
    logic [2:0] tx_en;
    logic [2:0] rx_en;
    logic [2:0] ld_vec;
    logic [2:0] host_mask;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            tx_en[p]     = ctrl[p][CTRL_TX];
            rx_en[p]     = ctrl[p][CTRL_RX];
            ld_vec[p]    = ctrl[p][CTRL_LD];
            host_mask[p] = ctrl[p][CTRL_TT];
        end
    end

    // Register decode
    wire wr_c0  = wr && (addr == ADDR_CTRL0);
    wire wr_c1  = wr && (addr == ADDR_CTRL1);
    wire wr_c2  = wr && (addr == ADDR_CTRL2);
    wire wr_fl  = wr && (addr == ADDR_FLUSH);
    wire [2:0] wr_ctrl = {wr_c2, wr_c1, wr_c0};

    // Readback port states
    port_state_e st [NPORT];
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            if (ctrl[p][2:0] == 3'h4) begin
                st[p] = ST_DISCARD;
            end else if (ctrl[p][2:0] == 3'h0) begin
                st[p] = ST_LEARN;
            end else if (ctrl[p][2:0] == 3'h3) begin
                st[p] = ST_FORWARD;
            end else begin
                st[p] = ST_ODD;
            end
        end
    end

    // Status word: host mask, port states, drop count
    // Gap bits read as zero so the layout can grow
    wire [31:0] status_word = {8'h00, drop_cnt, 6'h00, st[2], st[1], st[0],
                               1'b0, host_mask};

    // Read mux; unmapped reads as zero
    wire [31:0] rd_mux =
        (addr == ADDR_CTRL0)  ? {28'h000_0000, ctrl[0]} :
        (addr == ADDR_CTRL1)  ? {28'h000_0000, ctrl[1]} :
        (addr == ADDR_CTRL2)  ? {28'h000_0000, ctrl[2]} :
        (addr == ADDR_STATUS) ? status_word :
        32'h0000_0000;

    // Control writes; flush acts only on ports not learning
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int p = 0; p < NPORT; p++) begin
                ctrl[p] <= CTRL_RESET;
            end
            flush <= 3'h0;
            rdata <= 32'h0000_0000;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_ctrl[p]) begin
                    ctrl[p] <= wdata[3:0];
                end
            end
            flush <= wr_fl ? (wdata[2:0] & ld_vec & ~host_mask) : 3'h0;
            rdata <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Descriptor FIFO; its ready is ours
    wire out_free = !verdict_valid || verdict_ready;
    wire pop      = f_valid && out_free;
    stp_desc_fifo #(
        .WIDTH($bits(pkt_desc_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .in_valid (desc_valid),
        .in_data  (desc),
        .in_ready (desc_ready),
        .out_valid(f_valid),
        .out_data (head),
        .out_ready(pop)
    );

    // Gating terms for the head packet
    wire [2:0] src_oh  = 3'h1 << head.src;
    wire [3:0] rx4     = {1'b0, rx_en};
    wire [3:0] ld4     = {1'b1, ld_vec};
    wire src_is_host   = |(src_oh & host_mask);
    wire rx_ok         = rx4[head.src];
    wire ld_src        = ld4[head.src];
    // Host egress never blocked by its own bits
    // host traffic both ways
    wire [2:0] tx_ok   = tx_en | host_mask;
    wire [2:0] lk_fwd  = head.dst & ~src_oh & tx_ok;
    wire [2:0] tag_fwd = head.tag_ports & ~src_oh &
                         (head.tag_ovr ? 3'h7 : tx_ok);
    wire [2:0] host_fwd = head.tag_lookup ? lk_fwd : tag_fwd;
    wire [2:0] ovr_fwd  = head.static_ovr ?
                          (head.dst & host_mask & ~src_oh) : 3'h0;
    wire [2:0] nh_fwd   = rx_ok ? lk_fwd : ovr_fwd;
    wire [2:0] fwd_sel  = src_is_host ? host_fwd : nh_fwd;
    wire learn_sel      = src_is_host || !ld_src;

    // Verdict register; held while the sink stalls
    always_ff @(posedge clk) begin
        if (reset) begin
            verdict_valid <= 1'b0;
            verdict       <= '0;
        end else if (out_free) begin
            verdict_valid <= f_valid;
            if (pop) begin
                verdict.fwd   <= fwd_sel;
                verdict.learn <= learn_sel;
                verdict.drop  <= (fwd_sel == 3'h0);
            end
        end
    end

    // Drop counter, wraps
    always_ff @(posedge clk) begin
        if (reset) begin
            drop_cnt <= 8'h00;
        end else if (pop && (fwd_sel == 3'h0)) begin
            drop_cnt <= drop_cnt + 8'h01;
        end
    end

    // Checks
    // Non-host source packet leaving the FIFO this cycle
    wire nh_pop = pop && !src_is_host;

    a_rx_block_drop:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop && !rx_ok && !head.static_ovr |=> verdict.fwd == 3'h0)
        else $error("blocked port forwarded");

    a_ovr_to_host:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop && !rx_ok |=> verdict.fwd == $past(ovr_fwd))
        else $error("override frame not sent to host");

    a_tx_gate_hold:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop |=> (verdict.fwd & ~$past(tx_ok)) == 3'h0)
        else $error("disabled egress used");

    a_learn_off:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop && ld_src |=> !verdict.learn)
        else $error("learning while disabled");

    a_learn_on:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop && !ld_src |=> verdict.learn)
        else $error("learning missing");

    a_tag_override:
    assert property (@(posedge clk) disable iff (reset)
        pop && src_is_host && !head.tag_lookup |=> verdict.fwd == $past(tag_fwd))
        else $error("tail tag ports not honoured");

    a_flush_gate:
    assert property (@(posedge clk) disable iff (reset)
        (flush & ~$past(ld_vec)) == 3'h0)
        else $error("flush while learning");

    a_verdict_hold:
    assert property (@(posedge clk) disable iff (reset)
        verdict_valid && !verdict_ready |=> verdict_valid && $stable(verdict))
        else $error("verdict dropped under stall");

    a_host_readback:
    assert property (@(posedge clk) disable iff (reset)
        rd && addr == ADDR_STATUS |=> rdata[2:0] == $past(host_mask))
        else $error("host mask readback wrong");

    // Closed receive may only reach the host
    a_blocked_host_only:
    assert property (@(posedge clk) disable iff (reset)
        nh_pop && !rx_ok |=> (verdict.fwd & ~$past(host_mask)) == 3'h0)
        else $error("blocked port reached a user port");

    a_host_learn:
    assert property (@(posedge clk) disable iff (reset)
        pop && src_is_host |=> verdict.learn)
        else $error("host frame not learned");

    a_host_lookup:
    assert property (@(posedge clk) disable iff (reset)
        pop && src_is_host && head.tag_lookup |=> verdict.fwd == $past(lk_fwd))
        else $error("host lookup path wrong");

    // Counter must see every dropped packet
    a_drop_count:
    assert property (@(posedge clk) disable iff (reset)
        pop && (fwd_sel == 3'h0) |=> drop_cnt == $past(drop_cnt) + 8'h01)
        else $error("drop count missed a packet");

    c_ovr_host:
    cover property (@(posedge clk) disable iff (reset)
        nh_pop && !rx_ok && ovr_fwd != 3'h0);
    c_forward:
    cover property (@(posedge clk) disable iff (reset)
        nh_pop && rx_ok && lk_fwd != 3'h0);
    c_tag_ovr:
    cover property (@(posedge clk) disable iff (reset)
        pop && src_is_host && head.tag_ovr && !head.tag_lookup);
    c_learning:
    cover property (@(posedge clk) disable iff (reset)
        nh_pop && !rx_ok && !ld_src);
endmodule : stp_gate

//--- stp_gate_pkg.sv
// Constants, register map and packet carriers for the spanning tree port gate.
// Assumes a three-port switch core on one 10 MHz clock.
package stp_gate_pkg;
    // Number of switch ports
    localparam int NPORT = 3;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL0  = 8'h00;
    localparam logic [7:0] ADDR_CTRL1  = 8'h04;
    localparam logic [7:0] ADDR_CTRL2  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_FLUSH  = 8'h10;
    // Port control field positions
    localparam int CTRL_TX = 0;
    localparam int CTRL_RX = 1;
    localparam int CTRL_LD = 2;
    localparam int CTRL_TT = 3;
    // Port control reset: forwarding, no tail tag
    localparam logic [3:0] CTRL_RESET = 4'h3;
    // Status field positions
    localparam int STAT_HOST = 0;
    localparam int STAT_STATE = 4;
    localparam int STAT_DROP = 16;
    // Descriptor FIFO depth
    localparam int FIFO_DEPTH = 8;
    // Decoded port state, for readback
    typedef enum logic [1:0] {
        ST_DISCARD,
        ST_LEARN,
        ST_FORWARD,
        ST_ODD
    } port_state_e;
    // One packet decision request
    typedef struct packed {
        logic [1:0] src;        // Ingress port
        logic [2:0] dst;        // Lookup result mask
        logic       static_ovr; // Static entry with override hit
        logic       tag_lookup; // Host tail tag: use lookup
        logic       tag_ovr;    // Host tail tag: ignore blocking
        logic [2:0] tag_ports;  // Host tail tag: egress ports
    } pkt_desc_s;
    // Gate verdict for one packet
    typedef struct packed {
        logic [2:0] fwd;   // Egress ports allowed
        logic       learn; // Learn source address
        logic       drop;  // No egress at all
    } pkt_verdict_s;
endpackage : stp_gate_pkg

//--- test_spanning_tree_port_gate.sv
// Self-checking bench for the spanning tree port gate.
// Assumes stp_gate_pkg, stp_gate and host_sink compile first.
`timescale 1ns/1ps
module test_spanning_tree_port_gate;
    import stp_gate_pkg::*;
    logic         clk, reset, wr, rd, desc_valid, stall;
    logic [7:0]   addr;
    logic [31:0]  wdata, rdata;
    pkt_desc_s    desc;
    pkt_verdict_s verdict;
    logic         desc_ready, verdict_valid, verdict_ready;
    logic [2:0]   flush;
    logic [7:0]   taken;
    int           n_fail = 0;
    int           checked = 0;
    stp_gate DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .desc_valid(desc_valid),
        .desc(desc), .desc_ready(desc_ready), .verdict_valid(verdict_valid),
        .verdict(verdict), .verdict_ready(verdict_ready), .flush(flush));
    host_sink host (.clk(clk), .reset(reset), .stall(stall),
        .verdict_valid(verdict_valid), .verdict(verdict),
        .verdict_ready(verdict_ready), .taken(taken));
    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e); // readback
    endtask : rd_chk
    // One descriptor in, its verdict judged when taken
    task automatic send(input pkt_desc_s d, input pkt_verdict_s e);
        int i;
        @(posedge clk);
        desc_valid <= 1'b1;
        desc <= d;
        @(posedge clk);
        while (!desc_ready) @(posedge clk);
        desc_valid <= 1'b0;
        for (i = 0; i < 20 && !(verdict_valid && verdict_ready); i++) @(posedge clk);
        chk({27'h000_0000, verdict}, {27'h000_0000, e}); // verdict
        if (i == 20) chk(0, 1); // verdict timed out
    endtask : send
    task automatic t_reset;
        rd_chk(ADDR_CTRL0, 32'h0000_0003); // default forwarding
        rd_chk(8'h14, 32'h0000_0000); // unmapped reads zero
        rd_chk(ADDR_STATUS, 32'h0000_02A0); // no host yet
        send(11'b00_110_0_0_0_000, 5'b110_1_0); // forwards normally
    endtask : t_reset
    task automatic t_discard;
        wr_reg(ADDR_CTRL2, 32'h0000_000B);
        wr_reg(ADDR_CTRL0, 32'h0000_0004);
        send(11'b00_110_0_0_0_000, 5'b000_0_1);
        send(11'b00_110_1_0_0_000, 5'b100_0_0); // override to host
    endtask : t_discard
    task automatic t_learning;
        wr_reg(ADDR_CTRL0, 32'h0000_0000);
        send(11'b00_010_0_0_0_000, 5'b000_1_1); // learn, no egress
        send(11'b01_001_0_0_0_000, 5'b000_1_1); // tx off blocks
        send(11'b01_100_0_0_0_000, 5'b100_1_0); // port 2 unaffected
        rd_chk(ADDR_STATUS, 32'h0003_0294); // states and drops
    endtask : t_learning
    task automatic t_host;
        // nothing reaches port 0 without a tag override
        send(11'b10_000_0_0_0_011, 5'b010_1_0); // blocked port skipped
        send(11'b10_000_0_0_1_011, 5'b011_1_0); // blocking ignored
        send(11'b10_011_0_1_0_000, 5'b010_1_0); // lookup path
    endtask : t_host
    task automatic t_flush;
        wr_reg(ADDR_CTRL0, 32'h0000_0004);
        // Host with learning off must still never flush
        wr_reg(ADDR_CTRL2, 32'h0000_000C);
        wr_reg(ADDR_FLUSH, 32'h0000_0007);
        #1 chk({29'h0, flush}, 32'h0000_0001); // only port 0 flushed
        @(posedge clk);
        #1 chk({29'h0, flush}, 32'h0000_0000); // single pulse
    endtask : t_flush
    // Fill the FIFO with the host stalled, then drain it
    task automatic t_fifo;
        int n, m, i;
        n = 0;
        m = 0;
        @(posedge clk);
        stall <= 1'b1;
        desc_valid <= 1'b1;
        desc <= 11'b01_100_0_0_0_000;
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            if (desc_ready) n++;
        end
        desc_valid <= 1'b0;
        chk(n, FIFO_DEPTH + 1); // FIFO plus verdict stage
        stall <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (verdict_valid && verdict_ready) begin
                m++;
                chk({27'h0, verdict}, 32'h0000_0012); // every packet
            end
        end
        chk(m, n); // one verdict each
        chk({24'h00_0000, taken}, 32'h0000_000F); // host took every delivered frame
    endtask : t_fifo
    // Reset in mid-run restores forwarding and clears state
    task automatic t_rereset;
        wr_reg(ADDR_CTRL1, 32'h0000_0004);
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 chk({31'h0000_0000, desc_ready}, 32'h0000_0001); // FIFO accepting again
        rd_chk(ADDR_CTRL1, 32'h0000_0003); // forwarding restored
        rd_chk(ADDR_STATUS, 32'h0000_02A0); // no host, drops cleared
        send(11'b01_001_0_0_0_000, 5'b001_1_0); // gating after reset
    endtask : t_rereset
    task automatic final_report;
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // Watchdog well beyond the expected run
    initial begin
        #(100 * 3000);
        n_fail++;
        final_report();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        {wr, rd, desc_valid, stall} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        desc = 11'h000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_discard();
        t_learning();
        t_host();
        t_flush();
        t_fifo();
        t_rereset();
        final_report();
    end
endmodule : test_spanning_tree_port_gate
